// file: rtl/charger_protection_fault_sequencer.sv
`timescale 1ns/1ps
`include "fault_seq_map.svh"
module charger_protection_fault_sequencer #(
  parameter int unsigned TICK_CYC      = `TICK_US * `CLK_MHZ,
  parameter int unsigned SHORT_OFF_CYC = `SHORT_OFF_US * `CLK_MHZ,
  parameter int unsigned SHORT_ON_CYC  = `SHORT_ON_MS * 1000 * `CLK_MHZ,
  parameter int unsigned PULSE_CYC     = `IRQ_PULSE_US * `CLK_MHZ,
  parameter int unsigned OCP_LOCK_CNT  = `OCP_LOCK_CNT
) (
  input  logic                    mclk,
  input  logic                    rst_n,
  input  logic                    ce,
  input  fault_seq_pkg::sense_t   sense,
  input  fault_seq_pkg::axilReq_t busReq,
  output fault_seq_pkg::axilRsp_t busRsp,
  output fault_seq_pkg::drive_t   drive
);
  import fault_seq_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  sense_t      s1Q;
  sense_t      sQ;
  drive_t      drvQ;
  logic [16:0] tickCntQ;
  logic        tickQ;
  logic [7:0]  ctrlQ;
  logic [23:0] safetyQ;
  logic [2:0]  eventQ;
  logic        awReadyQ, wReadyQ, bValidQ, arReadyQ, rValidQ;
  logic        awHaveQ, wHaveQ;
  logic [1:0]  bRespQ, rRespQ;
  logic [31:0] rDataQ, wDataQ, rdNext;
  logic [7:0]  awAddrQ;
  logic [3:0]  wStrbQ;
  logic        rdOk;
  shortState_t shStQ;
  logic [19:0] shCntQ;
  logic [3:0]  shTriesQ;
  logic        deplQ, deplPrevQ, powerQ;
  ocpState_t   ocStQ;
  logic [11:0] ocCntQ, ocWinQ;
  logic [2:0]  ocHitsQ;
  logic        ocWinActQ, sawDropQ;
  phase_t      phPrevQ;
  logic [23:0] stCntQ;
  logic        halfQ, chgDisQ;
  logic [17:0] wdCntQ;
  logic        wdArmedQ, regResetQ;
  logic [13:0] pulseCntQ;
  logic [3:0]  railOkQ;

  // Two-stage input synchroniser
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1Q <= '0;
      sQ  <= '0;
    end else if (ce) begin
      s1Q <= sense;
      sQ  <= s1Q;
    end
  end

  // Millisecond time base
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tickCntQ <= '0;
      tickQ    <= 1'b0;
    end else if (ce) begin
      tickQ    <= (tickCntQ == 17'(TICK_CYC - 1));
      tickCntQ <= (tickCntQ == 17'(TICK_CYC - 1)) ? '0 : tickCntQ + 17'h1;
    end
  end

  // AXI4-Lite slave
  wire awTake  = busReq.awvalid & awReadyQ;
  wire wTake   = busReq.wvalid & wReadyQ;
  wire arTake  = busReq.arvalid & arReadyQ;
  wire doWrite = awHaveQ & wHaveQ & ~bValidQ;
  wire wrMap   = (awAddrQ == `OFF_CTRL) | (awAddrQ == `OFF_SAFETY) |
                 (awAddrQ == `OFF_STATUS) | (awAddrQ == `OFF_EVENTS);
  wire stWrite = doWrite & (awAddrQ == `OFF_SAFETY);
  wire evRead  = arTake & (busReq.araddr == `OFF_EVENTS);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      awReadyQ <= 1'b0;
      wReadyQ  <= 1'b0;
      awHaveQ  <= 1'b0;
      wHaveQ   <= 1'b0;
      bValidQ  <= 1'b0;
      bRespQ   <= 2'h0;
      awAddrQ  <= 8'h00;
      wDataQ   <= 32'h0;
      wStrbQ   <= 4'h0;
    end else if (ce) begin
      awReadyQ <= ~awHaveQ & ~awTake & ~bValidQ & ~doWrite;
      wReadyQ  <= ~wHaveQ & ~wTake & ~bValidQ & ~doWrite;
      if (awTake) begin
        awHaveQ <= 1'b1;
        awAddrQ <= busReq.awaddr;
      end else if (doWrite) begin
        awHaveQ <= 1'b0;
      end
      if (wTake) begin
        wHaveQ <= 1'b1;
        wDataQ <= busReq.wdata;
        wStrbQ <= busReq.wstrb;
      end else if (doWrite) begin
        wHaveQ <= 1'b0;
      end
      if (doWrite) begin
        bValidQ <= 1'b1;
        bRespQ  <= wrMap ? 2'h0 : 2'h2;
      end else if (bValidQ & busReq.bready) begin
        bValidQ <= 1'b0;
      end
    end
  end

  always_comb begin
    rdNext = 32'h0;
    rdOk   = 1'b1;
    case (busReq.araddr)
      `OFF_CTRL:   rdNext = {24'h0, ctrlQ};
      `OFF_SAFETY: rdNext = {8'h0, safetyQ};
      `OFF_STATUS: rdNext = {27'h0, chgDisQ, (phPrevQ != PH_OFF), (ocStQ[1]), deplQ,
                             (shStQ == SH_HOLD)};
      `OFF_EVENTS: rdNext = {29'h0, eventQ};
      default:     rdOk   = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      arReadyQ <= 1'b0;
      rValidQ  <= 1'b0;
      rDataQ   <= 32'h0;
      rRespQ   <= 2'h0;
    end else if (ce) begin
      arReadyQ <= ~rValidQ & ~arTake;
      if (arTake) begin
        rValidQ <= 1'b1;
        rDataQ  <= rdNext;
        rRespQ  <= rdOk ? 2'h0 : 2'h2;
      end else if (rValidQ & busReq.rready) begin
        rValidQ <= 1'b0;
      end
    end
  end

  assign busRsp.awready = awReadyQ;
  assign busRsp.wready  = wReadyQ;
  assign busRsp.bvalid  = bValidQ;
  assign busRsp.bresp   = bRespQ;
  assign busRsp.arready = arReadyQ;
  assign busRsp.rvalid  = rValidQ;
  assign busRsp.rdata   = rDataQ;
  assign busRsp.rresp   = rRespQ;

  // Control registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrlQ   <= `CTRL_RST;
      safetyQ <= `SAFETY_RST;
    end else if (ce) begin
      if (regResetQ) begin
        ctrlQ   <= `CTRL_RST;
        safetyQ <= `SAFETY_RST;
      end else if (doWrite & (awAddrQ == `OFF_CTRL)) begin
        ctrlQ <= 8'(merge({24'h0, ctrlQ}, wDataQ, wStrbQ));
      end else if (stWrite) begin
        safetyQ <= 24'(merge({8'h0, safetyQ}, wDataQ, wStrbQ));
      end
    end
  end

  // Watchdog
  wire        busTxn  = awTake | arTake;
  wire [1:0]  wdSel   = ctrlQ[`WD_SEL];
  wire [17:0] wdLimit = (wdSel == 2'b10) ? 18'(`WD_SHORT_MS - 1) : 18'(`WD_LONG_MS - 1);
  wire        wdFire  = wdArmedQ & (wdSel != 2'b11) & tickQ & (wdCntQ == wdLimit);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wdArmedQ  <= 1'b0;
      wdCntQ    <= '0;
      regResetQ <= 1'b0;
    end else if (ce) begin
      regResetQ <= wdFire & (wdSel == 2'b00);
      if (busTxn) begin
        wdArmedQ <= 1'b1;
        wdCntQ   <= '0;
      end else if (wdSel == 2'b11) begin
        wdCntQ <= '0;
      end else if (wdFire) begin
        wdArmedQ <= 1'b0;
        wdCntQ   <= '0;
      end else if (wdArmedQ & tickQ) begin
        wdCntQ <= wdCntQ + 18'h1;
      end
    end
  end

  // Output rail short retry sequencing
  wire holdEnter = sQ.adapterValid & (shStQ == SH_ON) & ~sQ.sysShortRelease &
                   (shCntQ == 20'(SHORT_ON_CYC - 1)) & (shTriesQ == 4'(`SHORT_TRIES));
  wire holdEnd   = sQ.adapterValid & (shStQ == SH_HOLD) & tickQ &
                   (shCntQ == 20'(`SHORT_HOLD_MS - 1));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shStQ    <= SH_IDLE;
      shCntQ   <= '0;
      shTriesQ <= '0;
    end else if (ce) begin
      if (!sQ.adapterValid) begin
        shStQ    <= SH_IDLE;
        shCntQ   <= '0;
        shTriesQ <= '0;
      end else begin
        case (shStQ)
          SH_IDLE: begin
            if (sQ.sysShort) begin
              shStQ    <= SH_OFF;
              shCntQ   <= '0;
              shTriesQ <= '0;
            end
          end
          SH_OFF: begin
            if (shCntQ == 20'(SHORT_OFF_CYC - 1)) begin
              shStQ    <= SH_ON;
              shCntQ   <= '0;
              shTriesQ <= shTriesQ + 4'h1;
            end else begin
              shCntQ <= shCntQ + 20'h1;
            end
          end
          SH_ON: begin
            if (sQ.sysShortRelease) begin
              shStQ  <= SH_IDLE;
              shCntQ <= '0;
            end else if (holdEnter) begin
              shStQ    <= SH_HOLD;
              shCntQ   <= '0;
              shTriesQ <= '0;
            end else if (shCntQ == 20'(SHORT_ON_CYC - 1)) begin
              shStQ  <= SH_OFF;
              shCntQ <= '0;
            end else begin
              shCntQ <= shCntQ + 20'h1;
            end
          end
          SH_HOLD: begin
            if (holdEnd) begin
              shStQ    <= SH_ON;
              shCntQ   <= '0;
              shTriesQ <= 4'h1;
            end else if (tickQ) begin
              shCntQ <= shCntQ + 20'h1;
            end
          end
          default: shStQ <= SH_IDLE;
        endcase
      end
    end
  end

  // Depletion and battery undervoltage
  wire deplRise = deplQ & ~deplPrevQ;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      deplQ     <= 1'b1;
      deplPrevQ <= 1'b1;
      powerQ    <= 1'b0;
    end else if (ce) begin
      deplPrevQ <= deplQ;
      if (!sQ.battAboveDepl) begin
        deplQ <= 1'b1;
      end else if (sQ.battAboveDeplRel) begin
        deplQ <= 1'b0;
      end
      powerQ <= sQ.adapterValid | sQ.battAboveUvlo;
    end
  end

  // Battery overcurrent hiccup and lockout
  wire        supPg  = sQ.supplementMode & sQ.inputPowerGood;
  wire        ocTrip = (ocStQ == OC_ON) & sQ.batOcp & drvQ.batterySwitch;
  wire [2:0]  ocHits = ocHitsQ + 3'h1;
  wire        ocWinE = ocWinActQ & tickQ & (ocWinQ == 12'(`OCP_WIN_MS - 1));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ocStQ     <= OC_ON;
      ocCntQ    <= '0;
      ocWinQ    <= '0;
      ocHitsQ   <= '0;
      ocWinActQ <= 1'b0;
      sawDropQ  <= 1'b0;
    end else if (ce) begin
      if (ocTrip & ~ocWinActQ) begin
        ocWinActQ <= 1'b1;
        ocWinQ    <= '0;
      end else if (ocWinE) begin
        ocWinActQ <= 1'b0;
      end else if (ocWinActQ & tickQ) begin
        ocWinQ <= ocWinQ + 12'h1;
      end
      case (ocStQ)
        OC_ON: begin
          if (ocTrip) begin
            ocHitsQ  <= ocHits;
            ocCntQ   <= '0;
            sawDropQ <= 1'b0;
            if (supPg) begin
              ocStQ <= OC_TOGGLE;
            end else if (ocHits >= 3'(OCP_LOCK_CNT)) begin
              ocStQ <= OC_LOCK;
            end else begin
              ocStQ <= OC_WAIT;
            end
          end else if (ocWinE) begin
            ocHitsQ <= '0;
          end
        end
        OC_WAIT: begin
          if (tickQ & (ocCntQ == 12'(`OCP_OFF_MS - 1))) begin
            ocStQ <= OC_ON;
          end else if (tickQ) begin
            ocCntQ <= ocCntQ + 12'h1;
          end
        end
        OC_LOCK: begin
          if (sQ.inputPowerGood) begin
            ocStQ   <= OC_ON;
            ocHitsQ <= '0;
          end
        end
        OC_TOGGLE: begin
          if (!sQ.inputPowerGood) begin
            sawDropQ <= 1'b1;
          end else if (sawDropQ) begin
            ocStQ   <= OC_ON;
            ocHitsQ <= '0;
          end
        end
        default: ocStQ <= OC_ON;
      endcase
    end
  end

  // Charge safety timer
  phase_t     ph;
  assign ph = phase_t'(sQ.chargePhase);
  wire        phEnter = ((ph == PH_PRE) & (phPrevQ != PH_PRE)) |
                        ((ph == PH_CC) & (phPrevQ == PH_PRE)) |
                        ((ph != PH_OFF) & (phPrevQ == PH_OFF));
  wire        running = (ph != PH_OFF) & ~chgDisQ & ~sQ.chargeDone;
  wire [23:0] stLimit = (ph == PH_PRE) ? {2'b00, safetyQ[23:2]} : safetyQ;
  wire        stExp   = running & ~phEnter & ~stWrite & ~sQ.supplementMode & (stCntQ >= stLimit);
  wire        slow    = ctrlQ[`F_DOUBLE] & sQ.otherLoopActive & (ph != PH_PRE);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phPrevQ <= PH_OFF;
      stCntQ  <= '0;
      halfQ   <= 1'b0;
      chgDisQ <= 1'b0;
    end else if (ce) begin
      phPrevQ <= ph;
      if (ph == PH_OFF) begin
        chgDisQ <= 1'b0;
        stCntQ  <= '0;
      end else if (phEnter | (stWrite & running)) begin
        stCntQ <= '0;
        halfQ  <= 1'b0;
      end else if (stExp) begin
        chgDisQ <= 1'b1;
      end else if (running & ~sQ.supplementMode & tickQ) begin
        if (slow) begin
          halfQ <= ~halfQ;
          if (halfQ) stCntQ <= stCntQ + 24'h1;
        end else begin
          stCntQ <= stCntQ + 24'h1;
        end
      end
    end
  end

  // Event flags and interrupt pulse
  wire irqTrig = (holdEnter & ~ctrlQ[`F_SHORT_BLK]) | (deplRise & ~ctrlQ[`F_DEPL_BLK]) | stExp;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      eventQ    <= '0;
      pulseCntQ <= '0;
    end else if (ce) begin
      eventQ <= (eventQ & ~{3{evRead}}) | {stExp, deplRise, holdEnter};
      if (irqTrig) begin
        pulseCntQ <= 14'(PULSE_CYC);
      end else if (pulseCntQ != '0) begin
        pulseCntQ <= pulseCntQ - 14'h1;
      end
    end
  end

  // Pin drive
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      drvQ      <= '0;
      drvQ.intN <= 1'b1;
      railOkQ   <= '0;
    end else if (ce) begin
      railOkQ <= (railOkQ | sQ.railAboveRise) & ~sQ.railBelowFall;
      drvQ.inputFetOn <= sQ.adapterValid & ((shStQ == SH_IDLE) | (shStQ == SH_ON));
      drvQ.batterySwitch <= powerQ & (ocStQ == OC_ON) &
                            ((~sQ.inputPowerGood & ~deplQ) |
                             (supPg & sQ.battAboveDepl) |
                             ((shStQ == SH_HOLD) & sQ.battAboveDepl));
      drvQ.intN <= ~(irqTrig | (pulseCntQ > 14'h1));
      drvQ.hardwareRestart <= wdFire & wdSel[0] ^ wdFire & wdSel[1];
      drvQ.devicePowerOn <= powerQ;
      drvQ.chargeEnable <= ~chgDisQ;
      if (sQ.hsLimit) begin
        drvQ.hsOn <= 1'b0;
        drvQ.lsOn <= 1'b1;
      end else if (sQ.lsBelowLimit | ~drvQ.lsOn) begin
        drvQ.hsOn <= 1'b1;
        drvQ.lsOn <= 1'b0;
      end
      drvQ.railEnable <= railOkQ & ~{4{ctrlQ[`F_SEQ] & sQ.sequenceUndervoltage}};
      drvQ.cellDepletionLevel <= ctrlQ[`F_LVL];
    end
  end

  assign drive = drvQ;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || !ce);

  sequence s_lowPulse;
    !drive.intN [*8];
  endsequence
  sequence s_switchOff;
    (ocStQ != OC_ON) ##1 !drive.batterySwitch;
  endsequence

  property p_short_off;
    (shStQ == SH_IDLE && sQ.adapterValid && sQ.sysShort) |=> ##1 !drive.inputFetOn;
  endproperty
  a_short_off: assert property (p_short_off) else $error("fet on after short");
  property p_hold;
    holdEnter |=> shStQ == SH_HOLD && shTriesQ == 4'h0 && eventQ[0];
  endproperty
  a_hold: assert property (p_hold) else $error("hold entry wrong");
  property p_hold_end;
    holdEnd |=> shStQ == SH_ON && shTriesQ == 4'h1 ##1 drive.inputFetOn;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("hold exit wrong");
  property p_depl_irq;
    (deplRise && !ctrlQ[`F_DEPL_BLK]) |=> s_lowPulse;
  endproperty
  a_depl_irq: assert property (p_depl_irq) else $error("no depletion pulse");
  property p_uvlo;
    (!sQ.adapterValid && !sQ.battAboveUvlo) |=> ##1 !drive.devicePowerOn;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("power kept below uvlo");
  property p_ocp;
    ocTrip |=> s_switchOff;
  endproperty
  a_ocp: assert property (p_ocp) else $error("switch kept on");
  property p_lock;
    (ocStQ == OC_LOCK && !sQ.inputPowerGood) |=> ocStQ == OC_LOCK;
  endproperty
  a_lock: assert property (p_lock) else $error("lockout left early");
  property p_st_exp;
    stExp |=> chgDisQ && eventQ[2] ##1 !drive.chargeEnable && !drive.intN;
  endproperty
  a_st_exp: assert property (p_st_exp) else $error("timer fault missed");
  property p_pause;
    (running && sQ.supplementMode && !phEnter && !stWrite) |=> $stable(stCntQ);
  endproperty
  a_pause: assert property (p_pause) else $error("timer ran in supplement");
  property p_wd;
    busTxn |=> wdArmedQ && wdCntQ == 18'h0;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog not restarted");
  property p_seq;
    (ctrlQ[`F_SEQ] && sQ.sequenceUndervoltage) |=> drive.railEnable == 4'h0;
  endproperty
  a_seq: assert property (p_seq) else $error("rail on in undervoltage");
  property p_buck;
    sQ.hsLimit |=> !drive.hsOn && drive.lsOn;
  endproperty
  a_buck: assert property (p_buck) else $error("high side kept on");
endmodule : charger_protection_fault_sequencer

// file: rtl/fault_seq_map.svh
`ifndef FAULT_SEQ_MAP_SVH
`define FAULT_SEQ_MAP_SVH
`define CLK_MHZ       100
`define TICK_US       1000
`define SHORT_OFF_US  200
`define SHORT_ON_MS   5
`define SHORT_TRIES   10
`define SHORT_HOLD_MS 2000
`define OCP_OFF_MS    250
`define OCP_WIN_MS    2000
`define OCP_LOCK_CNT  4
`define IRQ_PULSE_US  128
`define WD_LONG_MS    160000
`define WD_SHORT_MS   40000
`define OFF_CTRL      8'h00
`define OFF_SAFETY    8'h04
`define OFF_STATUS    8'h08
`define OFF_EVENTS    8'h0c
`define CTRL_RST      8'h00
`define SAFETY_RST    24'h36ee80
`define F_DOUBLE      2
`define F_SEQ         3
`define F_SHORT_BLK   4
`define F_DEPL_BLK    5
`define F_LVL         7:6
`define WD_SEL        1:0
`endif

// file: rtl/fault_seq_pkg.sv
package fault_seq_pkg;
  typedef struct packed {
    logic       adapterValid;
    logic       sysShort;
    logic       sysShortRelease;
    logic       battAboveDepl;
    logic       battAboveDeplRel;
    logic       battAboveUvlo;
    logic       batOcp;
    logic       inputPowerGood;
    logic       supplementMode;
    logic [1:0] chargePhase;
    logic       chargeDone;
    logic       otherLoopActive;
    logic       hsLimit;
    logic       lsBelowLimit;
    logic       sequenceUndervoltage;
    logic [3:0] railAboveRise;
    logic [3:0] railBelowFall;
  } sense_t;
  typedef struct packed {
    logic       inputFetOn;
    logic       batterySwitch;
    logic       intN;
    logic       hardwareRestart;
    logic       devicePowerOn;
    logic       chargeEnable;
    logic       hsOn;
    logic       lsOn;
    logic [3:0] railEnable;
    logic [1:0] cellDepletionLevel;
  } drive_t;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axilReq_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axilRsp_t;
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00, SH_OFF = 2'b01, SH_ON = 2'b10, SH_HOLD = 2'b11
  } shortState_t;
  typedef enum logic [1:0] {
    OC_ON = 2'b00, OC_WAIT = 2'b01, OC_LOCK = 2'b10, OC_TOGGLE = 2'b11
  } ocpState_t;
  typedef enum logic [1:0] {
    PH_OFF = 2'b00, PH_PRE = 2'b01, PH_CC = 2'b10, PH_CV = 2'b11
  } phase_t;
endpackage : fault_seq_pkg

// file: tb/analog_env.sv
`timescale 1ns/1ps
module analog_env (
  input  wire logic                  mclk,
  input  wire fault_seq_pkg::sense_t want,
  output fault_seq_pkg::sense_t      sense
);
  import fault_seq_pkg::*;
  // Comparators settle one edge after a level moves
  always_ff @(posedge mclk) begin
    sense <= want;
  end
endmodule : analog_env

// file: tb/charger_protection_fault_sequencer_test.sv
`timescale 1ns/1ps
`include "fault_seq_map.svh"
module charger_protection_fault_sequencer_test;
  import fault_seq_pkg::*;
  logic     mclk;
  logic     rst_n;
  sense_t   want;
  sense_t   sense;
  axilReq_t req;
  axilRsp_t rsp;
  drive_t   drv;
  logic     ce;
  int       sel;
  int       n;
  int       mismatches;
  int       tests_run;

  analog_env env (.mclk(mclk), .want(want), .sense(sense));
  charger_protection_fault_sequencer #(
    .TICK_CYC(10), .SHORT_OFF_CYC(20), .SHORT_ON_CYC(50), .PULSE_CYC(16)
  ) uut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .sense(sense),
    .busReq(req), .busRsp(rsp), .drive(drv)
  );

  function automatic logic probe();
    case (sel)
      0: return drv.inputFetOn;
      1: return drv.intN;
      default: return drv.batterySwitch;
    endcase
  endfunction : probe

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk("bresp", 32'h0, rsp.bresp);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge mclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    chk("rdata", e, rsp.rdata & m);
    chk("rresp", er, rsp.rresp);
  endtask : rd

  task automatic waitFor(input logic lvl, input int lim);
    int k;
    k = 0;
    while (probe() !== lvl && k < lim) begin
      @(posedge mclk);
      k++;
    end
    chk("level", lvl, probe());
  endtask : waitFor

  task automatic runLen();
    logic v;
    v = probe();
    n = 0;
    while (probe() === v && n < 30000) begin
      @(posedge mclk);
      n++;
    end
  endtask : runLen

  task automatic test_regs();
    rd(`OFF_CTRL, 32'hffffffff, 32'h0, 2'b00);
    rd(`OFF_SAFETY, 32'hffffffff, 32'h36ee80, 2'b00);
    rd(8'h10, 32'h0, 32'h0, 2'b10);
    $display("register test done");
  endtask : test_regs

  task automatic test_short();
    sel = 0;
    want.adapterValid <= 1'b1;
    want.inputPowerGood <= 1'b1;
    want.sysShort <= 1'b1;
    waitFor(1'b1, 20);
    waitFor(1'b0, 100);
    runLen();
    chk("fet off", 20, n);
    runLen();
    chk("fet on", 50, n);
    chk("batt idle", 0, drv.batterySwitch);
    sel = 1;
    waitFor(1'b0, 1000);
    repeat (4) @(posedge mclk);
    chk("fet hold", 0, drv.inputFetOn);
    chk("batt feeds", 1, drv.batterySwitch);
    rd(`OFF_STATUS, 32'h1, 32'h1, 2'b00);
    rd(`OFF_EVENTS, 32'h1, 32'h1, 2'b00);
    rd(`OFF_EVENTS, 32'h1, 32'h0, 2'b00);
    sel = 0;
    runLen();
    chk("hold", 1, n > 19900 && n <= 20000);
    runLen();
    chk("retry on", 50, n);
    rd(`OFF_STATUS, 32'h1, 32'h0, 2'b00);
    want.sysShort <= 1'b0;
    want.sysShortRelease <= 1'b1;
    $display("short test done");
  endtask : test_short

  task automatic test_depl();
    sel = 2;
    want.adapterValid <= 1'b0;
    want.inputPowerGood <= 1'b0;
    waitFor(1'b1, 20);
    chk("power", 1, drv.devicePowerOn);
    want.battAboveDepl <= 1'b0;
    want.battAboveDeplRel <= 1'b0;
    sel = 1;
    waitFor(1'b0, 20);
    runLen();
    chk("pulse", 16, n);
    chk("switch", 0, drv.batterySwitch);
    rd(`OFF_STATUS, 32'h2, 32'h2, 2'b00);
    rd(`OFF_EVENTS, 32'h2, 32'h2, 2'b00);
    want.battAboveUvlo <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("power off", 0, drv.devicePowerOn);
    $display("depletion test done");
  endtask : test_depl

  task automatic test_ocp();
    sel = 2;
    want.battAboveUvlo <= 1'b1;
    want.battAboveDepl <= 1'b1;
    want.battAboveDeplRel <= 1'b1;
    waitFor(1'b1, 20);
    want.batOcp <= 1'b1;
    waitFor(1'b0, 20);
    want.batOcp <= 1'b0;
    runLen();
    chk("hiccup", 1, n >= 2480 && n <= 2510);
    want.batOcp <= 1'b1;
    repeat (6000) @(posedge mclk);
    chk("lockout", 0, drv.batterySwitch);
    rd(`OFF_STATUS, 32'h4, 32'h4, 2'b00);
    want.batOcp <= 1'b0;
    want.inputPowerGood <= 1'b1;
    want.supplementMode <= 1'b1;
    waitFor(1'b1, 20);
    want.batOcp <= 1'b1;
    waitFor(1'b0, 20);
    want.batOcp <= 1'b0;
    repeat (3000) @(posedge mclk);
    chk("toggle wait", 0, drv.batterySwitch);
    want.inputPowerGood <= 1'b0;
    repeat (8) @(posedge mclk);
    want.inputPowerGood <= 1'b1;
    waitFor(1'b1, 20);
    $display("overcurrent test done");
  endtask : test_ocp

  task automatic test_timer();
    wr(`OFF_SAFETY, 32'h8);
    want.chargePhase <= 2'b10;
    repeat (200) @(posedge mclk);
    chk("paused", 1, drv.chargeEnable);
    want.supplementMode <= 1'b0;
    repeat (200) @(posedge mclk);
    chk("timer stop", 0, drv.chargeEnable);
    rd(`OFF_EVENTS, 32'h4, 32'h4, 2'b00);
    want.chargePhase <= 2'b00;
    $display("timer test done");
  endtask : test_timer

  task automatic test_seq();
    wr(`OFF_CTRL, 32'h8);
    rd(`OFF_CTRL, 32'hff, 32'h8, 2'b00);
    repeat (8) @(posedge mclk);
    chk("rails", 4'hf, drv.railEnable);
    want.sequenceUndervoltage <= 1'b1;
    ce <= 1'b0;
    repeat (10) @(posedge mclk);
    chk("frozen", 4'hf, drv.railEnable);
    ce <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("rails off", 4'h0, drv.railEnable);
    $display("sequence test done");
  endtask : test_seq

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    #1000000;
    mismatches++;
    test_done();
  end

  initial begin
    mismatches = 0;
    tests_run = 0;
    sel = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    req = '0;
    want = '0;
    want.battAboveDepl = 1'b1;
    want.battAboveDeplRel = 1'b1;
    want.battAboveUvlo = 1'b1;
    want.railAboveRise = 4'hf;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    test_regs();
    test_short();
    test_depl();
    test_ocp();
    test_timer();
    test_seq();
    test_done();
  end
endmodule : charger_protection_fault_sequencer_test
